// [bench/ism_contact_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ====================================
// Disconnector contacts, one pair per instance
module ism_contact_model
    import ism_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Wanted contact levels, bit 2i open, bit 2i+1 closed
    input wire logic [2*ISM_NUM_INST-1:0] want,
    input wire logic single,
    // Contacts
    output logic [ISM_NUM_INST-1:0] pos_open,
    output logic [ISM_NUM_INST-1:0] pos_closed
);
    initial begin
        pos_open = '0;
        pos_closed = '0;
    end
    // Contacts move just after an edge, like a real input stage
    always @(posedge aclk) begin
        for (int i = 0; i < ISM_NUM_INST; i++) begin
            pos_open[i] <= want[2*i];
            // One contact feeds both inputs, closed side inverted
            pos_closed[i] <= single ? !want[2*i] : want[2*i+1];
        end
    end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ism_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, single = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d, t;
    logic [1:0] bresp, rresp, r;
    logic [4:0] pos_open, pos_closed;
    logic [9:0] ind_state, want = '0;
    logic [15:0] lfsr_q = 16'h0022;
    int miscompares = 0, samples_checked = 0;
    always #12.5 aclk = ~aclk;
    // ====================================
    // Design and contacts
    ism_top #(.CYCLES_PER_MS(8)) ism_top_inst (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pos_open(pos_open), .pos_closed(pos_closed),
        .ind_state(ind_state), .irq(irq));
    ism_contact_model ism_contact_model_inst (.aclk(aclk), .want(want), .single(single),
        .pos_open(pos_open), .pos_closed(pos_closed));
    // ====================================
    // Helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [9:0] exp_state(input logic [9:0] w, input logic s);
        logic o, c;
        exp_state = '0;
        for (int i = 0; i < 5; i++) begin
            o = w[2*i];
            c = s ? !o : w[2*i+1];
            exp_state[2*i+:2] = (o && c) ? ISM_BAD : o ? ISM_OPEN : c ? ISM_CLOSED
                : ISM_INTERMEDIATE;
        end
    endfunction
    function automatic logic [31:0] exp_info(input logic [7:0] n, input logic [5:0] code);
        return {n != 8'h00, 7'h00, n, 10'h000, code};
    endfunction
    task automatic final_report;
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        repeat (50) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) begin
                rs = bresp;
                bready <= 0;
                @(posedge aclk);
                return;
            end
        end
        miscompares++;
        final_report;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        repeat (50) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) begin
                v = rdata;
                rs = rresp;
                rready <= 0;
                @(posedge aclk);
                return;
            end
        end
        miscompares++;
        final_report;
    endtask
    // ====================================
    // Main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk({22'h0, ind_state}, 32'h0);
        for (int n = 0; n < 24; n++) begin
            lfsr_q = lfsr_next(lfsr_q);
            want <= lfsr_q[9:0];
            single <= (n > 17) ? lfsr_q[15] : 1'b0;
            repeat (6) @(posedge aclk);
            chk({22'h0, ind_state}, {22'h0, exp_state(want, single)});
            rd(ISM_OFS_STATE, d, r);
            chk(d, {22'h0, exp_state(want, single)});
        end
        single <= 0;
        want <= '0;
        repeat (6) @(posedge aclk);
        wr(ISM_OFS_ON_MASK, 32'h0000_0002, r);
        wr(ISM_OFS_OFF_MASK, 32'h0000_0001, r);
        wr(ISM_OFS_IRQ_ENABLE, 32'h0000_0001, r);
        wr(ISM_OFS_CTRL, 32'h0000_0001, r);
        wr(ISM_OFS_ON_MASK, 32'hffff_ffff, r);
        chk({30'h0, r}, {30'h0, ISM_RESP_SLVERR});
        rd(ISM_OFS_ON_MASK, d, r);
        chk(d, 32'h0000_0002);
        want <= 10'h001;
        repeat (12) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        rd(ISM_OFS_EVT_INFO, d, r);
        chk(d, exp_info(8'd2, 6'h01));
        rd(ISM_OFS_EVT_STAMP, d, r);
        rd(ISM_OFS_TIME, t, r);
        chk({31'h0, (t - d) <= 32'd2 && d != 0}, 32'h1);
        wr(ISM_OFS_EVT_POP, 32'h0, r);
        rd(ISM_OFS_EVT_INFO, d, r);
        chk(d, exp_info(8'd1, 6'h20));
        wr(ISM_OFS_EVT_POP, 32'h0, r);
        wr(ISM_OFS_IRQ_CLEAR, 32'h0000_0001, r);
        // Both edges here are masked out, so nothing may be stored
        want <= 10'h002;
        repeat (12) @(posedge aclk);
        rd(ISM_OFS_EVT_INFO, d, r);
        chk(d, exp_info(8'd0, 6'h00));
        chk({31'h0, irq}, 32'h0);
        wr(ISM_OFS_CTRL, 32'h0, r);
        wr(12'h19c, 32'h4c_41_53_54, r);
        rd(12'h19c, d, r);
        chk(d, 32'h4c_41_53_54);
        rd(12'h1a0, d, r);
        chk({30'h0, r}, {30'h0, ISM_RESP_SLVERR});
        final_report;
    end
endmodule
`default_nettype wire

// [rtl/ism_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module ism_decode
    import ism_pkg::*;
(
    // Synchronised position contacts
    input wire logic open_pos,
    input wire logic closed_pos,
    // Decoded position
    output ism_state_t state,
    output logic [ISM_SIGS_PER_INST-1:0] status
);

    // ========================================================
    // Decode
    assign status[ISM_SIG_INTER] = !open_pos && !closed_pos;
    assign status[ISM_SIG_OPEN] = open_pos && !closed_pos;
    assign status[ISM_SIG_CLOSED] = closed_pos && !open_pos;
    assign status[ISM_SIG_BAD] = open_pos && closed_pos;

    always_comb begin
        if (status[ISM_SIG_BAD]) begin
            state = ISM_BAD;
        end else if (status[ISM_SIG_OPEN]) begin
            state = ISM_OPEN;
        end else if (status[ISM_SIG_CLOSED]) begin
            state = ISM_CLOSED;
        end else begin
            state = ISM_INTERMEDIATE;
        end
    end

endmodule
`default_nettype wire

// [rtl/ism_ms_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module ism_ms_timer
    import ism_pkg::*;
#(
    parameter int CYCLES_PER_MS = ISM_CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Time base
    output logic tick,
    output logic [ISM_STAMP_W-1:0] ms_count
);

    // Works with as little as one cycle per tick
    localparam int DIV_W = $clog2(CYCLES_PER_MS + 1);

    logic [DIV_W-1:0] div;
    wire logic div_end = div == DIV_W'(CYCLES_PER_MS - 1);

    // ========================================================
    // Divider and millisecond count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div <= '0;
            tick <= 1'b0;
            ms_count <= '0;
        end else begin
            div <= div_end ? '0 : div + 1'b1;
            tick <= div_end;
            if (div_end) begin
                ms_count <= ms_count + 1'b1;
            end
        end
    end

    ms_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tick |-> ms_count == $past(ms_count) + 1'b1)
        else $error("millisecond count did not step with tick");

    ms_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!tick && $past(aresetn)) |-> $stable(ms_count))
        else $error("millisecond count moved between ticks");

endmodule
`default_nettype wire

// [rtl/ism_pkg.sv]
package ism_pkg;

    // ========================================================
    // Sizes
    localparam int ISM_NUM_INST = 5;
    localparam int ISM_SIGS_PER_INST = 4;
    localparam int ISM_LABEL_CHARS = 32;
    localparam int ISM_LABEL_WORDS = ISM_LABEL_CHARS / 4;
    localparam int ISM_EVT_DEPTH = 16;
    localparam int ISM_STAMP_W = 32;
    localparam int ISM_CODE_W = 6;
    localparam int ISM_ADDR_W = 12;

    // ========================================================
    // Timing
    localparam int ISM_CLK_PERIOD_NS = 25;
    localparam int ISM_STAMP_RES_MS = 1;
    localparam int ISM_CYCLES_PER_MS = ISM_STAMP_RES_MS * 1000000 / ISM_CLK_PERIOD_NS;

    // ========================================================
    // Register map, byte addresses
    localparam logic [11:0] ISM_OFS_CTRL = 12'h000;
    localparam logic [11:0] ISM_OFS_STATE = 12'h004;
    localparam logic [11:0] ISM_OFS_ON_MASK = 12'h008;
    localparam logic [11:0] ISM_OFS_OFF_MASK = 12'h00c;
    localparam logic [11:0] ISM_OFS_IRQ_STATUS = 12'h010;
    localparam logic [11:0] ISM_OFS_IRQ_CLEAR = 12'h014;
    localparam logic [11:0] ISM_OFS_IRQ_ENABLE = 12'h018;
    localparam logic [11:0] ISM_OFS_TIME = 12'h01c;
    localparam logic [11:0] ISM_OFS_EVT_INFO = 12'h020;
    localparam logic [11:0] ISM_OFS_EVT_STAMP = 12'h024;
    localparam logic [11:0] ISM_OFS_EVT_POP = 12'h028;
    localparam logic [3:0] ISM_LABEL_PAGE = 4'h1;

    // ========================================================
    // Field positions and reset values
    localparam int ISM_CTRL_RUN = 0;
    localparam int ISM_SIG_INTER = 0;
    localparam int ISM_SIG_OPEN = 1;
    localparam int ISM_SIG_CLOSED = 2;
    localparam int ISM_SIG_BAD = 3;
    localparam int ISM_IRQ_W = 2;
    localparam int ISM_IRQ_STORED = 0;
    localparam int ISM_IRQ_OVERFLOW = 1;
    localparam int ISM_INFO_VALID = 31;
    localparam int ISM_INFO_COUNT = 16;
    localparam logic [31:0] ISM_MASK_RST = 32'h0000_0000;
    localparam logic [1:0] ISM_RESP_OKAY = 2'h0;
    localparam logic [1:0] ISM_RESP_SLVERR = 2'h2;

    // ========================================================
    // Position states
    typedef enum logic [1:0] {
        ISM_INTERMEDIATE = 2'b00,
        ISM_OPEN = 2'b01,
        ISM_CLOSED = 2'b10,
        ISM_BAD = 2'b11
    } ism_state_t;

endpackage

// [rtl/ism_top.sv]
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Neither contact active gives the intermediate state.
// - Both contacts active together give the bad state.
// - Open contact at one means the switch is open.
// - Closed contact at one means the switch is closed.
// - Each of the four status signals makes separate on and off events.
// - Every stored event carries a millisecond time stamp.
// - Per-event on and off enables choose which edges are stored.
// - Five independent instances, four status events each.
// - Each instance keeps a label of up to thirty-two characters.
// - Settings change only while monitoring is stopped.
// - Indication only; no command outputs towards the switch.
module ism_top
    import ism_pkg::*;
#(
    parameter int NUM_INST = ISM_NUM_INST,
    parameter int EVT_DEPTH = ISM_EVT_DEPTH,
    parameter int CYCLES_PER_MS = ISM_CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ISM_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ISM_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Position contacts, asynchronous
    input wire logic [NUM_INST-1:0] pos_open,
    input wire logic [NUM_INST-1:0] pos_closed,
    // Indication only, no command outputs
    output logic [2*NUM_INST-1:0] ind_state,
    output logic irq
);

    localparam int NUM_EV = NUM_INST * ISM_SIGS_PER_INST;
    localparam int NUM_LBL = NUM_INST * ISM_LABEL_WORDS;
    localparam int PTR_W = $clog2(EVT_DEPTH) + 1;

    // ========================================================
    // Functions
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b+:8] = nw[8*b+:8];
            end
        end
        return res;
    endfunction

    // Lowest set bit wins, so on edges drain before off edges
    function automatic logic [6:0] first_set(input logic [2*NUM_EV-1:0] v);
        logic [6:0] res;
        res = '0;
        for (int i = 2 * NUM_EV - 1; i >= 0; i--) begin
            if (v[i]) begin
                res = {1'b1, 6'(i)};
            end
        end
        return res;
    endfunction

    // ========================================================
    // Input synchronisers
    logic [NUM_INST-1:0] open_s1, open_s2, closed_s1, closed_s2;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            open_s1 <= '0;
            open_s2 <= '0;
            closed_s1 <= '0;
            closed_s2 <= '0;
        end else begin
            open_s1 <= pos_open;
            open_s2 <= open_s1;
            closed_s1 <= pos_closed;
            closed_s2 <= closed_s1;
        end
    end

    // ========================================================
    // Per-instance decode
    logic [2*NUM_INST-1:0] state_now;
    logic [NUM_EV-1:0] status_now;
    logic [NUM_EV-1:0] status_q;

    for (genvar gi = 0; gi < NUM_INST; gi++) begin : g_inst
        ism_decode u_dec (
            .open_pos(open_s2[gi]),
            .closed_pos(closed_s2[gi]),
            .state(state_now[2*gi+:2]),
            .status(status_now[4*gi+:4])
        );

        inter_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
            (!open_s2[gi] && !closed_s2[gi]) |=> ind_state[2*gi+:2] == ISM_INTERMEDIATE)
            else $error("no contact active but state not intermediate");

        bad_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
            (open_s2[gi] && closed_s2[gi]) |=> ind_state[2*gi+:2] == ISM_BAD)
            else $error("both contacts active but state not bad");

        open_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
            (open_s2[gi] && !closed_s2[gi]) |=> ind_state[2*gi+:2] == ISM_OPEN)
            else $error("open contact alone but state not open");

        closed_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
            (!open_s2[gi] && closed_s2[gi]) |=> ind_state[2*gi+:2] == ISM_CLOSED)
            else $error("closed contact alone but state not closed");
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ind_state <= '0;
            status_q <= {NUM_INST{ISM_SIGS_PER_INST'(1 << ISM_SIG_INTER)}};
        end else begin
            ind_state <= state_now;
            status_q <= status_now;
        end
    end

    wire logic [NUM_EV-1:0] on_edge = status_now & ~status_q;
    wire logic [NUM_EV-1:0] off_edge = ~status_now & status_q;

    // ========================================================
    // Time base
    logic ms_tick;
    logic [ISM_STAMP_W-1:0] ms_count;

    ism_ms_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(ms_tick),
        .ms_count(ms_count)
    );

    // ========================================================
    // Settings and status registers
    logic run;
    logic [NUM_EV-1:0] on_mask, off_mask;
    logic [ISM_IRQ_W-1:0] irq_status, irq_en;
    logic [31:0] label_mem [0:NUM_LBL-1];

    // ========================================================
    // Write channel
    logic [ISM_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    wire logic do_write = !awready && !wready && !bvalid;
    wire logic sel_ctrl = wr_addr == ISM_OFS_CTRL;
    wire logic sel_on = wr_addr == ISM_OFS_ON_MASK;
    wire logic sel_off = wr_addr == ISM_OFS_OFF_MASK;
    wire logic sel_clr = wr_addr == ISM_OFS_IRQ_CLEAR;
    wire logic sel_ien = wr_addr == ISM_OFS_IRQ_ENABLE;
    wire logic sel_pop = wr_addr == ISM_OFS_EVT_POP;
    wire logic sel_lbl = wr_addr[11:8] == ISM_LABEL_PAGE && wr_addr[7:2] < 6'(NUM_LBL);
    wire logic [5:0] lbl_wr_idx = wr_addr[7:2];
    // Settings are frozen while monitoring runs
    wire logic cfg_sel = sel_on || sel_off || sel_lbl;
    wire logic wr_ok = (cfg_sel && !run) || sel_ctrl || sel_clr || sel_ien || sel_pop;
    wire logic wr_eff = do_write && wr_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= ISM_RESP_OKAY;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= wr_ok ? ISM_RESP_OKAY : ISM_RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ========================================================
    // Event capture and buffer
    logic [NUM_EV-1:0] pend_on, pend_off;
    logic [ISM_CODE_W-1:0] mem_code [0:EVT_DEPTH-1];
    logic [ISM_STAMP_W-1:0] mem_stamp [0:EVT_DEPTH-1];
    logic [PTR_W-1:0] wr_ptr, rd_ptr;

    wire logic [6:0] pick = first_set({pend_off, pend_on});
    wire logic pick_valid = pick[6];
    wire logic [5:0] pick_idx = pick[5:0];
    wire logic [5:0] off_idx = pick_idx - 6'(NUM_EV);
    wire logic [ISM_CODE_W-1:0] pick_code = (pick_idx < 6'(NUM_EV)) ?
        {1'b0, pick_idx[4:0]} : {1'b1, off_idx[4:0]};
    wire logic [2*NUM_EV-1:0] take_vec = pick_valid ?
        ({{(2*NUM_EV-1){1'b0}}, 1'b1} << pick_idx) : '0;
    wire logic [PTR_W-1:0] fill = wr_ptr - rd_ptr;
    wire logic empty = wr_ptr == rd_ptr;
    wire logic full = fill == PTR_W'(EVT_DEPTH);
    wire logic push = pick_valid && !full;
    // A full buffer drops the lowest-numbered pending edge rather than stalling capture
    wire logic drop = pick_valid && full;
    wire logic pop = wr_eff && sel_pop && !empty;
    wire logic [PTR_W-2:0] wr_idx = wr_ptr[PTR_W-2:0];
    wire logic [PTR_W-2:0] rd_idx = rd_ptr[PTR_W-2:0];

    // New edges OR in after the take, so a new edge on the bit being taken stays pending
    wire logic [NUM_EV-1:0] next_pend_on = (pend_on & ~take_vec[NUM_EV-1:0]) |
        (run ? (on_edge & on_mask) : '0);
    wire logic [NUM_EV-1:0] next_pend_off = (pend_off & ~take_vec[2*NUM_EV-1:NUM_EV]) |
        (run ? (off_edge & off_mask) : '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_on <= '0;
            pend_off <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            pend_on <= next_pend_on;
            pend_off <= next_pend_off;
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (push) begin
            mem_code[wr_idx] <= pick_code;
            mem_stamp[wr_idx] <= ms_count;
        end
    end

    // ========================================================
    // Register updates and interrupt
    wire logic [ISM_IRQ_W-1:0] irq_set = {drop, push};
    wire logic [ISM_IRQ_W-1:0] irq_clr = (wr_eff && sel_clr) ? wr_data[ISM_IRQ_W-1:0] : '0;
    wire logic [31:0] on_new = merge(32'(on_mask), wr_data, wr_strb);
    wire logic [31:0] off_new = merge(32'(off_mask), wr_data, wr_strb);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run <= 1'b0;
            on_mask <= NUM_EV'(ISM_MASK_RST);
            off_mask <= NUM_EV'(ISM_MASK_RST);
            irq_en <= '0;
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_eff && sel_ctrl && wr_strb[0]) begin
                run <= wr_data[ISM_CTRL_RUN];
            end
            if (wr_eff && sel_on) begin
                on_mask <= on_new[NUM_EV-1:0];
            end
            if (wr_eff && sel_off) begin
                off_mask <= off_new[NUM_EV-1:0];
            end
            if (wr_eff && sel_ien && wr_strb[0]) begin
                irq_en <= wr_data[ISM_IRQ_W-1:0];
            end
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            irq <= |(irq_status & irq_en);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_LBL; i++) begin
                label_mem[i] <= '0;
            end
        end else if (wr_eff && sel_lbl) begin
            label_mem[lbl_wr_idx] <= merge(label_mem[lbl_wr_idx], wr_data, wr_strb);
        end
    end

    // ========================================================
    // Read channel
    logic [31:0] rd_word;
    logic rd_hit;
    wire logic [5:0] lbl_rd_idx = araddr[7:2];

    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        if (araddr == ISM_OFS_CTRL) begin
            rd_word[ISM_CTRL_RUN] = run;
        end else if (araddr == ISM_OFS_STATE) begin
            rd_word = 32'(ind_state);
        end else if (araddr == ISM_OFS_ON_MASK) begin
            rd_word = 32'(on_mask);
        end else if (araddr == ISM_OFS_OFF_MASK) begin
            rd_word = 32'(off_mask);
        end else if (araddr == ISM_OFS_IRQ_STATUS) begin
            rd_word = 32'(irq_status);
        end else if (araddr == ISM_OFS_IRQ_ENABLE) begin
            rd_word = 32'(irq_en);
        end else if (araddr == ISM_OFS_TIME) begin
            rd_word = ms_count;
        end else if (araddr == ISM_OFS_EVT_INFO) begin
            rd_word[ISM_INFO_VALID] = !empty;
            rd_word[ISM_INFO_COUNT+:8] = 8'(fill);
            rd_word[ISM_CODE_W-1:0] = empty ? '0 : mem_code[rd_idx];
        end else if (araddr == ISM_OFS_EVT_STAMP) begin
            rd_word = empty ? '0 : mem_stamp[rd_idx];
        end else if (araddr[11:8] == ISM_LABEL_PAGE && lbl_rd_idx < 6'(NUM_LBL)) begin
            rd_word = label_mem[lbl_rd_idx];
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= ISM_RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= rd_hit ? ISM_RESP_OKAY : ISM_RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ========================================================
    // Checks
    for (genvar ge = 0; ge < NUM_EV; ge++) begin : g_ev_chk
        on_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
            (run && on_edge[ge] && on_mask[ge]) |=> pend_on[ge])
            else $error("enabled on edge not captured");

        off_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
            (run && off_edge[ge] && off_mask[ge]) |=> pend_off[ge])
            else $error("enabled off edge not captured");

        mask_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
            (!on_mask[ge] && !pend_on[ge] && !off_mask[ge] && !pend_off[ge])
            |=> (!pend_on[ge] && !pend_off[ge]))
            else $error("masked edge reached the event buffer");
    end

    push_stamp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        push |=> mem_stamp[$past(wr_idx)] == $past(ms_count))
        else $error("stored event stamp differs from time base");

    cfg_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && do_write && cfg_sel) |=> ($stable(on_mask) && $stable(off_mask) && bresp == ISM_RESP_SLVERR))
        else $error("setting changed while monitoring runs");

    label_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_eff && sel_lbl && wr_strb == 4'hf) |=> label_mem[$past(lbl_wr_idx)] == $past(wr_data))
        else $error("label word not stored");

    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (irq_status & irq_en) != '0 |=> irq)
        else $error("enabled status bit did not raise interrupt");

endmodule
`default_nettype wire
